// [rtl/dcs_chain.sv]
// serial master for a daisy chain of one to three stepper driver chips
`timescale 1ns/100ps
module dcs_chain (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic cfg_load,
    input wire logic [7:0] chain_clock_divider,
    input wire logic [1:0] last_driver_index,
    input wire logic select_polarity,
    input wire logic clock_polarity,
    input wire logic phase_bit_polarity,
    input wire logic fast_decay_polarity,
    input wire logic current_bits_polarity,
    input wire logic select_mode_individual,
    input wire logic continuous_update,
    input wire logic motor_one_right_switch,
    input wire logic ref_multiplex,
    input wire logic [11:0] ramp_div_all,
    input wire logic [11:0] push_data,
    input wire logic push_valid,
    output logic push_ready,
    input wire logic switch_input_one,
    input wire logic switch_input_two,
    input wire logic switch_input_three,
    output logic chain_sck,
    output logic chain_sdo,
    output logic chain_select,
    output logic second_driver_select,
    output logic third_driver_select,
    output logic chain_busy,
    output logic [2:0] ref_left,
    output logic [2:0] ref_right
);
    typedef struct packed {
        dcs_pkg::dcs_phase_t st;
        logic [7:0] hcnt;
        logic [1:0] halves;
        logic sck;
        logic [3:0] bitcnt;
        logic [1:0] motor;
        logic [11:0] shreg;
        logic [2:0][11:0] held;
        logic [28:0] acc;
        logic pend;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] raw_r;
        logic [7:0] div;
        logic [1:0] last_idx;
        logic pol_sel;
        logic pol_sck;
        logic pol_ph;
        logic pol_fd;
        logic pol_dac;
        logic indiv;
        logic cupd;
        logic one_right;
        logic refmux;
        logic [2:0] ref_l;
        logic [2:0] ref_r;
        logic sck_o;
        logic sdo;
        logic sel_c;
        logic sel2;
        logic sel3;
        logic busy;
    } dcs_chain_state_t;

    // divider 15, switch bits cleared, selects idle
    localparam dcs_chain_state_t CHAIN_RST = '{st: dcs_pkg::ST_IDLE, div: dcs_pkg::DIV_RESET,
        sel_c: 1'b1, sel2: 1'b1, sel3: 1'b1, default: '0};

    dcs_chain_state_t s;
    dcs_chain_state_t next_s;
    logic load_word;
    logic [11:0] raw_word;
    logic [28:0] inc;
    logic [3:0] rd;
    logic tick;
    logic active;
    logic need;
    logic half_end;

    dcs_stream_if #(.W(dcs_pkg::WORD_W)) push_if ();
    dcs_stream_if #(.W(dcs_pkg::WORD_W)) pop_if ();

    assign push_if.data = push_data;
    assign push_if.valid = push_valid;
    assign push_ready = push_if.ready;
    // a word is drawn from the fifo at each driver slot while one waits
    assign pop_if.ready = load_word;

    dcs_fifo #(.W(dcs_pkg::WORD_W), .DEPTH(dcs_pkg::FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wr(push_if),
        .rd(pop_if)
    );

    always_comb begin
        next_s = s;
        load_word = 1'b0;
        raw_word = '0;
        inc = '0;
        rd = '0;
        tick = 1'b0;
        active = 1'b0;
        half_end = (s.hcnt == '0);
        need = pop_if.valid || s.pend;
        next_s.sync1 = {switch_input_three, switch_input_two, switch_input_one};
        next_s.sync2 = s.sync1;
        if (cfg_load) begin
            next_s.div = chain_clock_divider;
            next_s.last_idx = last_driver_index;
            next_s.pol_sel = select_polarity;
            next_s.pol_sck = clock_polarity;
            next_s.pol_ph = phase_bit_polarity;
            next_s.pol_fd = fast_decay_polarity;
            next_s.pol_dac = current_bits_polarity;
            next_s.indiv = select_mode_individual;
            next_s.cupd = continuous_update;
            next_s.one_right = motor_one_right_switch;
            next_s.refmux = ref_multiplex;
        end
        // rate accumulator, wraps at 2^28 = 32768 * 2^13
        for (int i = 0; i < dcs_pkg::NUM_MOTORS; i++) begin
            rd = ramp_div_all[i*4 +: 4];
            if (rd > dcs_pkg::RAMP_DIV_MAX) begin
                rd = dcs_pkg::RAMP_DIV_MAX;
            end
            inc = 29'(inc + (29'h1 << (dcs_pkg::RAMP_DIV_MAX - rd)));
        end
        if (s.cupd) begin
            next_s.acc = 29'(s.acc + inc);
            tick = next_s.acc[dcs_pkg::CUPD_WRAP_BIT];
            next_s.acc[dcs_pkg::CUPD_WRAP_BIT] = 1'b0;
        end else begin
            next_s.acc = '0;
        end
        // each half period lasts divider plus one cycles
        if (s.st != dcs_pkg::ST_IDLE) begin
            next_s.hcnt = half_end ? s.div : 8'(s.hcnt - 1'b1);
        end
        case (s.st)
            dcs_pkg::ST_IDLE: begin
                if (need) begin
                    next_s.st = dcs_pkg::ST_LEAD;
                    next_s.hcnt = s.div;
                    next_s.halves = dcs_pkg::LEAD_HALVES;
                    next_s.motor = '0;
                    next_s.pend = 1'b0;
                    next_s.busy = 1'b1;
                end
            end
            dcs_pkg::ST_LEAD: begin
                if (half_end) begin
                    if (s.halves == '0) begin
                        // mux shows the right bank while select is idle
                        next_s.raw_r = s.sync2;
                        next_s.st = dcs_pkg::ST_BITS;
                        next_s.bitcnt = '0;
                        load_word = 1'b1;
                    end else begin
                        next_s.halves = 2'(s.halves - 1'b1);
                    end
                end
            end
            dcs_pkg::ST_BITS: begin
                if (half_end) begin
                    if (!s.sck) begin
                        next_s.sck = 1'b1;
                    end else begin
                        next_s.sck = 1'b0;
                        next_s.shreg = {s.shreg[10:0], 1'b0};
                        if (s.bitcnt == dcs_pkg::BIT_LAST) begin
                            // chain length from last driver index
                            if (s.motor == s.last_idx) begin
                                next_s.st = dcs_pkg::ST_TAIL;
                                next_s.halves = dcs_pkg::TAIL_HALVES;
                            end else begin
                                next_s.st = dcs_pkg::ST_MARK;
                                next_s.halves = (s.div == dcs_pkg::DIV_FAST) ?
                                    dcs_pkg::MARK_HALVES_FAST : dcs_pkg::MARK_HALVES_SLOW;
                            end
                        end else begin
                            next_s.bitcnt = 4'(s.bitcnt + 1'b1);
                        end
                    end
                end
            end
            dcs_pkg::ST_MARK: begin
                if (half_end) begin
                    if (s.halves == '0) begin
                        next_s.motor = 2'(s.motor + 1'b1);
                        next_s.st = dcs_pkg::ST_BITS;
                        next_s.bitcnt = '0;
                        load_word = 1'b1;
                    end else begin
                        next_s.halves = 2'(s.halves - 1'b1);
                    end
                end
            end
            dcs_pkg::ST_TAIL: begin
                if (half_end) begin
                    if (s.halves == '0) begin
                        next_s.st = dcs_pkg::ST_IDLE;
                        next_s.busy = 1'b0;
                        if (s.refmux) begin
                            next_s.ref_l = s.sync2;
                            next_s.ref_r = s.raw_r;
                        // input three is motor one right
                        end else if (s.one_right) begin
                            next_s.ref_l = {1'b0, s.sync2[1:0]};
                            next_s.ref_r = {2'b00, s.sync2[2]};
                        end else begin
                            next_s.ref_l = s.sync2;
                            next_s.ref_r = '0;
                        end
                    end else begin
                        next_s.halves = 2'(s.halves - 1'b1);
                    end
                end
            end
            default: begin
                next_s.st = dcs_pkg::ST_IDLE;
            end
        endcase
        if (load_word) begin
            // idle slots repeat the last word so a refresh never changes the coils
            if (pop_if.valid) begin
                raw_word = pop_if.data;
                next_s.held[next_s.motor] = pop_if.data;
            end else begin
                raw_word = s.held[next_s.motor];
            end
            next_s.shreg = raw_word ^ ({12{s.pol_ph}} & dcs_pkg::PH_MASK)
                ^ ({12{s.pol_fd}} & dcs_pkg::FD_MASK) ^ ({12{s.pol_dac}} & dcs_pkg::DAC_MASK);
        end
        // the set from a tick wins over the clear at start
        if (tick) begin
            next_s.pend = 1'b1;
        end
        active = (next_s.st != dcs_pkg::ST_IDLE) && (next_s.st != dcs_pkg::ST_LEAD);
        next_s.sck_o = next_s.sck ^ s.pol_sck;
        next_s.sdo = next_s.shreg[dcs_pkg::WORD_W-1] && active;
        if (s.indiv) begin
            next_s.sel_c = !(active && (next_s.motor == 2'h0));
            next_s.sel2 = !(active && (next_s.motor == 2'h1));
            next_s.sel3 = !(active && (next_s.motor == 2'h2));
        end else begin
            // same line drives the switch multiplexer
            next_s.sel_c = s.pol_sel ? active : !active;
            next_s.sel2 = 1'b1;
            next_s.sel3 = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= CHAIN_RST;
        end else begin
            s <= next_s;
        end
    end

    assign chain_sck = s.sck_o;
    assign chain_sdo = s.sdo;
    assign chain_select = s.sel_c;
    assign second_driver_select = s.sel2;
    assign third_driver_select = s.sel3;
    assign chain_busy = s.busy;
    assign ref_left = s.ref_l;
    assign ref_right = s.ref_r;

    // checking helpers
    logic cfg_seen;
    logic [8:0] run_cnt;
    logic [9:0] mark_cnt;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_seen <= 1'b0;
            run_cnt <= '0;
            mark_cnt <= '0;
        end else begin
            cfg_seen <= cfg_seen || cfg_load;
            run_cnt <= ((s.sck != next_s.sck) || (s.st != dcs_pkg::ST_BITS)) ? 9'h000 : 9'(run_cnt + 1'b1);
            mark_cnt <= (s.st == dcs_pkg::ST_MARK) ? 10'(mark_cnt + 1'b1) : 10'h000;
        end
    end

    default clocking dcs_cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_div_default: assert property (!cfg_seen |-> s.div == dcs_pkg::DIV_RESET)
        else $error("divider left its reset value");
    a_sel_common_idle: assert property ((s.st == dcs_pkg::ST_IDLE) && !s.indiv && $stable(s.pol_sel)
        && ($past(s.st) == dcs_pkg::ST_IDLE) |-> chain_select == !s.pol_sel)
        else $error("shared select not idle at its polarity");
    a_sck_idle_level: assert property ((s.st == dcs_pkg::ST_IDLE) && $stable(s.pol_sck)
        && ($past(s.st) == dcs_pkg::ST_IDLE) |-> chain_sck == s.pol_sck)
        else $error("chain clock idle level wrong");
    a_half_period: assert property ((s.st == dcs_pkg::ST_BITS) && ($past(s.st) == dcs_pkg::ST_BITS)
        && (s.sck != $past(s.sck)) && $stable(s.div) |-> $past(run_cnt) == {1'b0, s.div})
        else $error("chain clock half period wrong");
    a_mark_length: assert property (($past(s.st) == dcs_pkg::ST_MARK) && (s.st != dcs_pkg::ST_MARK)
        |-> $past(mark_cnt) + 10'h001 == ((s.div == dcs_pkg::DIV_FAST) ? 10'h002 : 10'h003)
        * ({2'b00, s.div} + 10'h001))
        else $error("next motor marker length wrong");
    a_no_idle_send: assert property ((s.st == dcs_pkg::ST_IDLE) && !pop_if.valid && !s.pend
        |=> (s.st == dcs_pkg::ST_IDLE) || $past(cfg_load))
        else $error("datagram started without need");
    a_ref_hold_idle: assert property ((s.st == dcs_pkg::ST_IDLE) ##1 (s.st == dcs_pkg::ST_IDLE)
        |-> $stable(ref_left) && $stable(ref_right))
        else $error("switch state changed outside a datagram");
    a_indiv_low: assert property (s.indiv && (s.st == dcs_pkg::ST_BITS) && (s.motor == 2'h1)
        && $stable(s.motor) |-> !second_driver_select && chain_select && third_driver_select)
        else $error("individual select wrong");

    c_three_drivers: cover property ((s.st == dcs_pkg::ST_BITS) && (s.motor == 2'h2));
    c_cupd_refresh: cover property (tick ##[1:1000] (s.st == dcs_pkg::ST_LEAD));
    c_fifo_full: cover property (!push_ready);
    c_mux_sample: cover property (s.refmux && (s.st == dcs_pkg::ST_TAIL) ##[1:600] (s.st == dcs_pkg::ST_IDLE));
endmodule : dcs_chain

// [rtl/dcs_fifo.sv]
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module dcs_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    dcs_stream_if.snk wr,
    dcs_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic in_ready;
    } dcs_fifo_state_t;
    localparam dcs_fifo_state_t FIFO_RST = '{in_ready: 1'b1, default: '0};
    dcs_fifo_state_t s;
    dcs_fifo_state_t next_s;
    logic do_wr;
    logic do_rd;

    assign wr.ready = s.in_ready;
    assign rd.valid = (s.cnt != '0);
    assign rd.data = s.mem[s.rp];

    always_comb begin
        next_s = s;
        do_wr = wr.valid && s.in_ready;
        do_rd = rd.ready && (s.cnt != '0);
        if (do_wr) begin
            next_s.mem[s.wp] = wr.data;
            next_s.wp = AW'(s.wp + 1'b1);
        end
        if (do_rd) begin
            next_s.rp = AW'(s.rp + 1'b1);
        end
        if (do_wr && !do_rd) begin
            next_s.cnt = CW'(s.cnt + 1'b1);
        end else if (do_rd && !do_wr) begin
            next_s.cnt = CW'(s.cnt - 1'b1);
        end
        // registered so the source sees a clean ready
        next_s.in_ready = (next_s.cnt != CW'(DEPTH));
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= FIFO_RST;
        end else begin
            s <= next_s;
        end
    end
endmodule : dcs_fifo

// [rtl/dcs_pkg.sv]
// constants and types shared by the driver chain serial port
package dcs_pkg;
    localparam int WORD_W = 12;
    localparam int FIFO_DEPTH = 32;
    localparam int DIV_W = 8;
    localparam int NUM_MOTORS = 3;
    localparam logic [7:0] DIV_RESET = 8'h0f;
    localparam logic [7:0] DIV_FAST = 8'h07;
    localparam logic [11:0] PH_MASK = 12'hc00;
    localparam logic [11:0] FD_MASK = 12'h200;
    localparam logic [11:0] DAC_MASK = 12'h1fe;
    localparam logic [1:0] LEAD_HALVES = 2'h1;
    localparam logic [1:0] TAIL_HALVES = 2'h1;
    localparam logic [1:0] MARK_HALVES_FAST = 2'h1;
    localparam logic [1:0] MARK_HALVES_SLOW = 2'h2;
    localparam logic [3:0] BIT_LAST = 4'hb;
    localparam logic [3:0] RAMP_DIV_MAX = 4'hd;
    localparam int CUPD_ACC_W = 29;
    localparam int CUPD_WRAP_BIT = 28;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_LEAD = 5'h02,
        ST_BITS = 5'h04,
        ST_MARK = 5'h08,
        ST_TAIL = 5'h10
    } dcs_phase_t;
endpackage : dcs_pkg

// [rtl/dcs_stream_if.sv]
// valid/ready word stream between the fifo and the serialiser
`timescale 1ns/100ps
interface dcs_stream_if #(parameter int W = 12);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : dcs_stream_if

// [verification/dcs_chain_model.sv]
// driver chain and switch multiplexer model
`timescale 1ns/100ps
module dcs_chain_model (
    input wire logic chain_sck,
    input wire logic chain_sdo,
    input wire logic chain_select,
    input wire logic second_driver_select,
    input wire logic third_driver_select,
    input wire logic sel_inv,
    input wire logic sck_inv,
    input wire logic mux_on,
    input wire logic [2:0] sw_left,
    input wire logic [2:0] sw_right,
    output logic switch_input_one,
    output logic switch_input_two,
    output logic switch_input_three
);
    logic [35:0] sh = 36'h0;
    logic [35:0] rx [0:127];
    int nb = 0;
    int n = 0;
    logic [2:0] sw;
    wire logic act_main = chain_select ^ ~sel_inv;
    wire logic sel_act = act_main | ~second_driver_select | ~third_driver_select;
    wire logic sck_eff = chain_sck ^ sck_inv;
    always_comb begin
        sw = (mux_on & ~act_main) ? sw_right : sw_left;
        {switch_input_three, switch_input_two, switch_input_one} = sw;
    end
    // polarity changes may glitch the select, so restart on each assertion
    always @(posedge sel_act) begin
        nb = 0;
        sh = 36'h0;
    end
    always @(posedge sck_eff) begin
        if (sel_act === 1'b1) begin
            sh = {sh[34:0], chain_sdo};
            nb = nb + 1;
        end
    end
    // partial frames from glitches are dropped
    always @(negedge sel_act) begin
        if (nb >= 12) begin
            rx[n] = sh;
            n = n + 1;
        end
        nb = 0;
    end
endmodule : dcs_chain_model

// [verification/testbench.sv]
// self-checking bench for the driver chain serial port
`timescale 1ns/100ps
module testbench;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cfg_load = 1'b0;
    logic [7:0] div = 8'h0f;
    logic [1:0] lidx = 2'h0;
    logic spol = 1'b0, cpol = 1'b0, ppol = 1'b0, fpol = 1'b0, dpol = 1'b0;
    logic indiv = 1'b0, cu = 1'b0, m1r = 1'b0, mux = 1'b0;
    logic [11:0] ramp = 12'h000;
    logic [11:0] push_data = 12'h000;
    logic push_valid = 1'b0;
    logic [2:0] sw_l = 3'h5, sw_r = 3'h0;
    logic push_ready, in1, in2, in3, chain_sck, chain_sdo, chain_select, sel2, sel3, chain_busy;
    logic [2:0] ref_left, ref_right;
    logic saw2 = 1'b0, saw3 = 1'b0;
    int fails = 0;
    int compares = 0;
    dcs_chain uut (.ref_clk(ref_clk), .rst_b(rst_b), .cfg_load(cfg_load), .chain_clock_divider(div),
        .last_driver_index(lidx), .select_polarity(spol), .clock_polarity(cpol), .phase_bit_polarity(ppol),
        .fast_decay_polarity(fpol), .current_bits_polarity(dpol), .select_mode_individual(indiv),
        .continuous_update(cu), .motor_one_right_switch(m1r), .ref_multiplex(mux), .ramp_div_all(ramp),
        .push_data(push_data), .push_valid(push_valid), .push_ready(push_ready), .switch_input_one(in1),
        .switch_input_two(in2), .switch_input_three(in3), .chain_sck(chain_sck), .chain_sdo(chain_sdo),
        .chain_select(chain_select), .second_driver_select(sel2), .third_driver_select(sel3),
        .chain_busy(chain_busy), .ref_left(ref_left), .ref_right(ref_right));
    dcs_chain_model model (.chain_sck(chain_sck), .chain_sdo(chain_sdo), .chain_select(chain_select),
        .second_driver_select(sel2), .third_driver_select(sel3), .sel_inv(spol), .sck_inv(cpol),
        .mux_on(mux), .sw_left(sw_l), .sw_right(sw_r), .switch_input_one(in1), .switch_input_two(in2),
        .switch_input_three(in3));
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) begin
        if (sel2 === 1'b0) saw2 <= 1'b1;
        if (sel3 === 1'b0) saw3 <= 1'b1;
    end
    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic load;
        @(negedge ref_clk) cfg_load = 1'b1;
        @(negedge ref_clk) cfg_load = 1'b0;
    endtask : load
    // valid held up between calls, so back-to-back pushes need no gap
    task automatic push(input logic [11:0] w, output logic ok);
        @(negedge ref_clk);
        ok = push_ready;
        push_valid = ok;
        push_data = w;
    endtask : push
    task automatic stop;
        @(negedge ref_clk) push_valid = 1'b0;
    endtask : stop
    task automatic dg_len(output int len);
        int t;
        len = 0;
        for (t = 0; t < 30000 && chain_busy !== 1'b1; t++) @(negedge ref_clk);
        while (chain_busy === 1'b1 && len < 30000) begin
            @(negedge ref_clk);
            len++;
        end
    endtask : dg_len
    task automatic send(input logic [11:0] w0, w1, w2, input int nw, output int len);
        logic ok;
        fork
            begin
                push(w0, ok);
                if (nw > 1) push(w1, ok);
                if (nw > 2) push(w2, ok);
                stop;
            end
            dg_len(len);
        join
    endtask : send
    task automatic t_reset;
        int len;
        chk("push_ready", 36'h1, 36'(push_ready));
        chk("selects idle", 36'h7, 36'({chain_select, sel2, sel3}));
        chk("sck idle", 36'h0, 36'(chain_sck));
        send(12'h9c3, 12'h0, 12'h0, 1, len);
        chk("len div15", 36'd448, 36'(len));
        chk("word", 36'h9c3, model.rx[model.n-1]);
        chk("default map", 36'h28, 36'({ref_left, ref_right}));
        $display("test reset done");
    endtask : t_reset
    task automatic t_pol;
        int len;
        int k;
        logic [11:0] m [0:4];
        m = '{12'h000, dcs_pkg::PH_MASK, dcs_pkg::FD_MASK, dcs_pkg::DAC_MASK, 12'h000};
        div = 8'h07; // fastest legal divider
        for (k = 0; k < 5; k++) begin
            {ppol, fpol, dpol} = {k == 1, k == 2, k == 3};
            {spol, cpol} = {k == 4, k == 4};
            load;
            send(12'ha5c, 12'h0, 12'h0, 1, len);
            chk("pol word", 36'(12'ha5c ^ m[k]), model.rx[model.n-1]);
        end
        chk("len div7", 36'd224, 36'(len));
        chk("inverted idle", 36'h1, 36'(chain_sck & ~chain_select));
        {spol, cpol} = 2'b00;
        load;
        $display("test polarity done");
    endtask : t_pol
    task automatic t_chain;
        int len;
        {lidx, div} = {2'h2, 8'h08}; // three drivers, code 3 never used
        load;
        send(12'h111, 12'h222, 12'h333, 3, len);
        chk("len mark slow", 36'd738, 36'(len));
        chk("three words", 36'h111222333, model.rx[model.n-1]);
        chk("shared only", 36'h0, 36'({saw2, saw3}));
        {indiv, div} = {1'b1, 8'h07}; // select polarity stays low
        load;
        send(12'h444, 12'h555, 12'h666, 3, len);
        chk("len mark fast", 36'd640, 36'(len));
        chk("own selects", 36'h3, 36'({saw2, saw3}));
        {indiv, lidx} = {1'b0, 2'h0};
        load;
        $display("test chain done");
    endtask : t_chain
    task automatic t_refs;
        int len;
        int k;
        logic [5:0] e [0:3];
        e = '{6'h30, 6'h11, 6'h33, 6'h33};
        sw_l = 3'h6;
        sw_r = 3'h3;
        for (k = 0; k < 4; k++) begin
            {mux, m1r} = 2'(k);
            load;
            send(12'h0f0, 12'h0, 12'h0, 1, len);
            chk("switch map", 36'(e[k]), 36'({ref_left, ref_right}));
        end
        sw_l = 3'h1;
        sw_r = 3'h4;
        repeat (500) @(negedge ref_clk);
        chk("held outside frames", 36'h33, 36'({ref_left, ref_right}));
        send(12'h0f0, 12'h0, 12'h0, 1, len);
        chk("sampled in frame", 36'h0c, 36'({ref_left, ref_right}));
        {mux, m1r} = 2'b00;
        load;
        $display("test switches done");
    endtask : t_refs
    task automatic t_cu;
        int len;
        int t;
        int busy_cnt;
        cu = 1'b1; // periodic frames wanted
        load;
        dg_len(len);
        sw_l = 3'h2;
        for (t = 0; t < 20000 && chain_busy !== 1'b1; t++) @(negedge ref_clk);
        chk("update period", 36'h1, 36'((len + t) >= 10922 && (len + t) <= 10923));
        dg_len(len);
        chk("restart sample", 36'h10, 36'({ref_left, ref_right}));
        cu = 1'b0;
        load;
        repeat (1000) @(negedge ref_clk);
        busy_cnt = 0;
        repeat (3000) @(negedge ref_clk) busy_cnt += int'(chain_busy === 1'b1);
        chk("quiet at rest", 36'h0, 36'(busy_cnt));
        $display("test continuous done");
    endtask : t_cu
    task automatic t_fifo;
        int acc;
        int k;
        int n0;
        logic ok;
        n0 = model.n;
        acc = 0;
        ok = 1'b1;
        for (k = 0; k < 40 && ok; k++) begin
            push(12'(12'h100 + k), ok);
            acc += int'(ok);
        end
        stop;
        chk("fill depth", 36'h1, 36'(acc >= 32 && acc <= 34));
        for (k = 0; k < 20000 && model.n < n0 + acc; k++) @(negedge ref_clk);
        repeat (1000) @(negedge ref_clk);
        chk("frames drained", 36'(acc), 36'(model.n - n0));
        for (k = 0; k < acc; k++) chk("fifo order", 36'(12'h100 + k), model.rx[n0 + k]);
        $display("test fifo done");
    endtask : t_fifo
    task automatic results;
        $display("checks %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial begin
        #5000000;
        fails++;
        results;
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk) rst_b = 1'b1;
        t_reset;
        t_pol;
        t_chain;
        t_refs;
        t_cu;
        t_fifo;
        results;
    end
endmodule : testbench
